// ### rtl/csr_top.v
// Overview of operation
// - indirect port accesses register the pointer selects
// - pointer at zero reads zero, writes nothing
// - pointer low six bits select registers
// - pointer top bits choose one of four banks
// - special and shared registers mirrored across banks
// - single-bank pointer top bits read as one
// - timer counts instruction steps or pin edges, edge selectable
// - timer write clears prescaler when assigned
// - counter width per variant, five-deep return stack
// - counter advances on each instruction step unless loaded
// - high bits change only through defined paths
// - jump takes target, top bit from staging
// - call jumps and pushes next address
// - returns pop whole counter, staging untouched
// - low-byte write loads high bits from staging
// - staging feeds jumps only on largest variant
// - flag writes ignored when instruction sets flags
// - carry from add, no-borrow, rotate end bit
// - half carry from low nibble, zero on result
// - sleep and watchdog flags set and cleared
// - port read gives pins, write goes to latch
// - port a four bits, port c optional
//
// Local design decision: the Avalon-MM slave port.
`include "csr_defs.vh"

module csr_top #(
   parameter NUM_BANKS  = 4,
   parameter PC_W       = 11,
   parameter HAS_PORT_C = 1,
   parameter STK_DEPTH  = `CSR_STACK_DEPTH
) (
   // clock and reset
   input  wire            SYS_CLK_I,
   input  wire            RST_N_I,
   // avalon-mm slave
   input  wire [6:0]      AVS_ADDRESS_I,
   input  wire            AVS_READ_I,
   input  wire            AVS_WRITE_I,
   input  wire [31:0]     AVS_WRITEDATA_I,
   input  wire [3:0]      AVS_BYTEENABLE_I,
   output wire [31:0]     AVS_READDATA_O,
   output wire            AVS_WAITREQUEST_O,
   // program flow from the core
   input  wire            INSTR_STEP_I,
   input  wire            JUMP_I,
   input  wire            CALL_I,
   input  wire            RET_I,
   input  wire [9:0]      TARGET_I,
   output wire [PC_W-1:0] PC_O,
   // flag unit
   input  wire            ALU_EN_I,
   input  wire [2:0]      ALU_OP_I,
   input  wire [7:0]      ALU_A_I,
   input  wire [7:0]      ALU_B_I,
   output wire [7:0]      ALU_RES_O,
   // reset-status events
   input  wire            SLEEP_I,
   input  wire            WATCHDOG_CLEAR_OP_I,
   input  wire            WDT_OVF_I,
   // pins
   input  wire            TMR_PIN_I,
   input  wire [3:0]      PORT_A_DATA_PIN_I,
   input  wire [7:0]      PORT_B_DATA_PIN_I,
   input  wire [7:0]      PORT_C_DATA_PIN_I,
   output wire [3:0]      PORT_A_DATA_O,
   output wire [7:0]      PORT_B_DATA_O,
   output wire [7:0]      PORT_C_DATA_O
);

   localparam ST_IDLE   = 3'b001;
   localparam ST_ACK    = 3'b010;
   localparam ST_DONE   = 3'b100;
   localparam BIG       = (PC_W == 11);
   localparam MEM_DEPTH = (NUM_BANKS == 4) ? 96 : 48;
   localparam [2:0] STG_MASK = (PC_W == 11) ? 3'h7 :
                               (PC_W == 10) ? 3'h3 : 3'h1;

   reg  [2:0]      state_r;
   reg             waitreq_r;
   reg  [31:0]     rdata_r;
   reg  [7:0]      tmr_r;
   reg  [7:0]      pre_r;
   reg  [7:0]      status_r;
   reg  [7:0]      st_nxt;
   reg  [7:0]      ptr_r;
   reg  [7:0]      opt_r;
   reg  [2:0]      stg_r;
   reg  [PC_W-1:0] pc_r;
   reg  [PC_W-1:0] pc_nxt;
   reg  [PC_W-1:0] stk_r [0:STK_DEPTH-1];
   reg  [3:0]      pa_lat_r;
   reg  [7:0]      pb_lat_r;
   reg  [7:0]      pc_lat_r;
   reg  [7:0]      alu_res_r;
   reg  [20:0]     s1_r;
   reg  [20:0]     s2_r;
   reg  [20:0]     s3_r;
   reg  [20:0]     flt_r;
   reg             tpin_d_r;
   reg  [7:0]      rd_mux;
   reg  [7:0]      bx;
   reg  [8:0]      sum9;
   reg  [4:0]      lo5;
   reg  [7:0]      alu_res;
   reg             alu_c;
   reg             alu_dc;
   reg  [2:0]      alu_aff;

   wire [7:0]      wd       = AVS_WRITEDATA_I[7:0];
   wire            in_file  = ~AVS_ADDRESS_I[6];
   wire            is_opt   = (AVS_ADDRESS_I == `CSR_A_OPTION);
   wire            is_ind   = in_file & (AVS_ADDRESS_I[5:0] == `CSR_A_INDIRECT);
   wire [5:0]      eff      = is_ind ? ptr_r[5:0] : AVS_ADDRESS_I[5:0];
   wire [1:0]      eff_bank = (NUM_BANKS == 4) ? ptr_r[7:6] : 2'b00;
   wire            is_gpr   = in_file & (eff >= `CSR_A_GPR_LO);
   // write lands at the edge where the master sees waitrequest low
   wire            wr_go    = (state_r == ST_DONE) & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
   wire            wr_file  = wr_go & in_file;
   wire            wr_tmr   = wr_file & (eff == `CSR_A_TIMER);
   wire            wr_pcl   = wr_file & (eff == `CSR_A_PCL);
   wire            wr_st    = wr_file & (eff == `CSR_A_STATUS);
   wire            wr_ptr   = wr_file & (eff == `CSR_A_POINTER);
   wire            wr_pa    = wr_file & (eff == `CSR_A_PORT_A_DATA);
   wire            wr_pb    = wr_file & (eff == `CSR_A_PORT_B_DATA);
   wire            wr_pc    = wr_file & (eff == `CSR_A_PORT_C_DATA);
   wire            wr_stg   = wr_file & (eff == `CSR_A_STAGING);
   wire            wr_mem   = wr_go & is_gpr;
   wire            wr_opt   = wr_go & is_opt;
   wire [6:0]      gidx_sh  = {1'b0, eff} - {1'b0, `CSR_A_GPR_LO};
   wire [6:0]      gidx_bk  = 7'h20 + {1'b0, eff_bank, eff[3:0]};
   // upper sixteen locations are per bank, the rest shared
   wire [6:0]      gidx     = ((NUM_BANKS == 4) && (eff >= `CSR_A_BANKED)) ?
                              gidx_bk : gidx_sh;
   wire [7:0]      mem_rdata;
   wire [20:0]     agree    = ~(s2_r ^ s3_r);
   wire [3:0]      pa_in    = flt_r[3:0];
   wire [7:0]      pb_in    = flt_r[11:4];
   wire [7:0]      pc_in    = flt_r[19:12];
   wire            tpin     = flt_r[20];
   wire            t_rise   = tpin & ~tpin_d_r;
   wire            t_fall   = ~tpin & tpin_d_r;
   wire [2:0]      ps       = opt_r[`CSR_OPT_PS_MSB:`CSR_OPT_PS_LSB];
   wire            prescaler_assign      = opt_r[`CSR_OPT_PSA];
   wire            tick     = opt_r[`CSR_OPT_SRC] ?
                              (opt_r[`CSR_OPT_EDGE] ? t_fall : t_rise) :
                              INSTR_STEP_I;
   wire [7:0]      pre_mask = (8'h02 << ps) - 8'h01;
   wire            tmr_inc  = tick & (prescaler_assign | ((pre_r & pre_mask) == pre_mask));
   wire [10:0]     pcl_load = {stg_r, wd};
   wire [10:0]     jmp_full = {(BIG ? stg_r[2] : 1'b0), TARGET_I};
   wire            pop      = RET_I & ~wr_pcl;
   wire            push     = CALL_I & ~wr_pcl & ~RET_I;
   wire [PC_W-1:0] pc_inc   = pc_r + {{(PC_W-1){1'b0}}, 1'b1};

   assign AVS_READDATA_O    = rdata_r;
   assign AVS_WAITREQUEST_O = waitreq_r;
   assign PC_O              = pc_r;
   assign ALU_RES_O         = alu_res_r;
   assign PORT_A_DATA_O           = pa_lat_r;
   assign PORT_B_DATA_O           = pb_lat_r;
   assign PORT_C_DATA_O           = pc_lat_r;

   csr_gpr_mem #(
      .DW    (8),
      .DEPTH (MEM_DEPTH),
      .AW    (7)
   ) u_gpr (
      .clk_i   (SYS_CLK_I),
      .we_i    (wr_mem),
      .addr_i  (gidx),
      .wdata_i (wd),
      .rdata_o (mem_rdata)
   );

   // bus handshake: memory read in idle, waitrequest low with the answer two cycles later
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         state_r   <= ST_IDLE;
         waitreq_r <= 1'b1;
         rdata_r   <= 32'h0000_0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (AVS_READ_I | AVS_WRITE_I) begin
                  state_r <= ST_ACK;
               end
            end
            ST_ACK: begin
               waitreq_r <= 1'b0;
               rdata_r   <= {24'h00_0000, rd_mux};
               state_r   <= ST_DONE;
            end
            ST_DONE: begin
               waitreq_r <= 1'b1;
               state_r   <= ST_IDLE;
            end
            default: begin
               waitreq_r <= 1'b1;
               state_r   <= ST_IDLE;
            end
         endcase
      end
   end

   // read selection
   always @* begin
      rd_mux = 8'h00;
      if (is_opt) begin
         rd_mux = opt_r;
      end else if (in_file) begin
         case (eff)
            `CSR_A_INDIRECT: rd_mux = 8'h00;
            `CSR_A_TIMER:    rd_mux = tmr_r;
            `CSR_A_PCL:      rd_mux = pc_r[7:0];
            `CSR_A_STATUS:   rd_mux = status_r;
            `CSR_A_POINTER:  rd_mux = (NUM_BANKS == 4) ? ptr_r :
                                      {2'b11, ptr_r[5:0]};
            `CSR_A_PORT_A_DATA:    rd_mux = {4'h0, pa_in};
            `CSR_A_PORT_B_DATA:    rd_mux = pb_in;
            `CSR_A_PORT_C_DATA:    rd_mux = HAS_PORT_C ? pc_in : pc_lat_r;
            `CSR_A_STAGING:  rd_mux = {5'h00, stg_r};
            default:         rd_mux = is_gpr ? mem_rdata : 8'h00;
         endcase
      end
   end

   // flag unit; subtraction adds the two's complement
   always @* begin
      bx      = (ALU_OP_I == `CSR_OP_SUB) ? ~ALU_B_I : ALU_B_I;
      sum9    = {1'b0, ALU_A_I} + {1'b0, bx} +
                {8'h00, (ALU_OP_I == `CSR_OP_SUB)};
      lo5     = {1'b0, ALU_A_I[3:0]} + {1'b0, bx[3:0]} +
                {4'h0, (ALU_OP_I == `CSR_OP_SUB)};
      alu_res = ALU_A_I;
      alu_c   = 1'b0;
      alu_dc  = 1'b0;
      alu_aff = 3'b000;
      case (ALU_OP_I)
         `CSR_OP_ADD, `CSR_OP_SUB: begin
            alu_res = sum9[7:0];
            alu_c   = sum9[8];
            alu_dc  = lo5[4];
            alu_aff = 3'b111;
         end
         `CSR_OP_RL: begin
            alu_res = {ALU_A_I[6:0], status_r[`CSR_ST_C]};
            alu_c   = ALU_A_I[7];
            alu_aff = 3'b001;
         end
         `CSR_OP_RR: begin
            alu_res = {status_r[`CSR_ST_C], ALU_A_I[7:1]};
            alu_c   = ALU_A_I[0];
            alu_aff = 3'b001;
         end
         `CSR_OP_LOGIC: begin
            alu_aff = 3'b100;
         end
         default: begin
            alu_aff = 3'b000;
         end
      endcase
   end

   // status: flag unit beats a same-cycle write, sets beat clears
   always @* begin
      st_nxt = status_r;
      if (wr_st) begin
         st_nxt[7:5] = wd[7:5];
         st_nxt[2:0] = wd[2:0];
      end
      if (ALU_EN_I) begin
         if (alu_aff[0]) st_nxt[`CSR_ST_C]  = alu_c;
         if (alu_aff[1]) st_nxt[`CSR_ST_DC] = alu_dc;
         if (alu_aff[2]) st_nxt[`CSR_ST_Z]  = (alu_res == 8'h00);
      end
      if (SLEEP_I) st_nxt[`CSR_ST_PD] = 1'b0;
      if (WATCHDOG_CLEAR_OP_I) st_nxt[`CSR_ST_PD] = 1'b1;
      if (WDT_OVF_I) st_nxt[`CSR_ST_TO] = 1'b0;
      if (WATCHDOG_CLEAR_OP_I | SLEEP_I) st_nxt[`CSR_ST_TO] = 1'b1;
   end

   // program counter; staging never copies back from it
   always @* begin
      pc_nxt = pc_r;
      if (wr_pcl) begin
         pc_nxt = pcl_load[PC_W-1:0];
      end else if (RET_I) begin
         pc_nxt = stk_r[0];
      end else if (JUMP_I | CALL_I) begin
         pc_nxt = jmp_full[PC_W-1:0];
      end else if (INSTR_STEP_I) begin
         pc_nxt = pc_inc;
      end
   end

   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         pc_r      <= {PC_W{1'b0}};
         status_r  <= `CSR_RST_STATUS;
         ptr_r     <= `CSR_RST_POINTER;
         opt_r     <= `CSR_RST_OPTION;
         stg_r     <= 3'h0;
         alu_res_r <= 8'h00;
         pa_lat_r  <= 4'h0;
         pb_lat_r  <= 8'h00;
         pc_lat_r  <= 8'h00;
      end else begin
         pc_r     <= pc_nxt;
         status_r <= st_nxt;
         if (ALU_EN_I) alu_res_r <= alu_res;
         if (wr_ptr) ptr_r <= wd;
         if (wr_opt) opt_r <= wd;
         if (wr_stg) stg_r <= wd[2:0] & STG_MASK;
         if (wr_pa) pa_lat_r <= wd[3:0];
         if (wr_pb) pb_lat_r <= wd;
         if (wr_pc) pc_lat_r <= wd;
      end
   end

   // return stack, entry 0 is the top; overflow drops the oldest
   genvar gi;
   generate
      for (gi = 0; gi < STK_DEPTH; gi = gi + 1) begin : g_stk
         always @(posedge SYS_CLK_I) begin
            if (!RST_N_I) begin
               stk_r[gi] <= {PC_W{1'b0}};
            end else if (push) begin
               if (gi == 0) begin
                  stk_r[gi] <= pc_inc;
               end else begin
                  stk_r[gi] <= stk_r[(gi == 0) ? 0 : gi-1];
               end
            end else if (pop) begin
               if (gi < STK_DEPTH - 1) begin
                  stk_r[gi] <= stk_r[(gi < STK_DEPTH - 1) ? gi+1 : gi];
               end
            end
         end
      end
   endgenerate

   // timer and prescaler; a write wins over a same-cycle count
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         tmr_r <= 8'h00;
         pre_r <= 8'h00;
      end else begin
         if (wr_tmr) begin
            tmr_r <= wd;
         end else if (tmr_inc) begin
            tmr_r <= tmr_r + 8'h01;
         end
         if (wr_tmr & ~prescaler_assign) begin
            pre_r <= 8'h00;
         end else if (tick & ~prescaler_assign) begin
            pre_r <= tmr_inc ? 8'h00 : pre_r + 8'h01;
         end
      end
   end

   // pin synchroniser; a level counts once stages two and three agree
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         s1_r     <= 21'h00_0000;
         s2_r     <= 21'h00_0000;
         s3_r     <= 21'h00_0000;
         flt_r    <= 21'h00_0000;
         tpin_d_r <= 1'b0;
      end else begin
         s1_r     <= {TMR_PIN_I, PORT_C_DATA_PIN_I, PORT_B_DATA_PIN_I, PORT_A_DATA_PIN_I};
         s2_r     <= s1_r;
         s3_r     <= s2_r;
         flt_r    <= (agree & s3_r) | (~agree & flt_r);
         tpin_d_r <= tpin;
      end
   end

endmodule // csr_top

// ### common/csr_defs.vh
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// register file offsets (word index on the bus)
`define CSR_A_INDIRECT   6'h00
`define CSR_A_TIMER      6'h01
`define CSR_A_PCL        6'h02
`define CSR_A_STATUS     6'h03
`define CSR_A_POINTER    6'h04
`define CSR_A_PORT_A_DATA      6'h05
`define CSR_A_PORT_B_DATA      6'h06
`define CSR_A_PORT_C_DATA      6'h07
`define CSR_A_STAGING    6'h0a
`define CSR_A_GPR_LO     6'h10
`define CSR_A_BANKED     6'h30
`define CSR_A_OPTION     7'h40

// status fields
`define CSR_ST_C         0
`define CSR_ST_DC        1
`define CSR_ST_Z         2
`define CSR_ST_PD        3
`define CSR_ST_TO        4

// option fields
`define CSR_OPT_PS_LSB   0
`define CSR_OPT_PS_MSB   2
`define CSR_OPT_PSA      3
`define CSR_OPT_EDGE     4
`define CSR_OPT_SRC      5

// reset values
`define CSR_RST_STATUS   8'h18
`define CSR_RST_OPTION   8'h00
`define CSR_RST_POINTER  8'h00

// flag unit operations
`define CSR_OP_ADD       3'h0
`define CSR_OP_SUB       3'h1
`define CSR_OP_RL        3'h2
`define CSR_OP_RR        3'h3
`define CSR_OP_LOGIC     3'h4

`define CSR_STACK_DEPTH  5

`endif

// ### rtl/csr_gpr_mem.v
module csr_gpr_mem #(
   parameter DW    = 8,
   parameter DEPTH = 96,
   parameter AW    = 7
) (
   // clock
   input  wire          clk_i,
   // access
   input  wire          we_i,
   input  wire [AW-1:0] addr_i,
   input  wire [DW-1:0] wdata_i,
   output reg  [DW-1:0] rdata_o
);

   reg [DW-1:0] mem_r [0:DEPTH-1];

   // read returns old data on a same-cycle write
   always @(posedge clk_i) begin
      if (we_i) begin
         mem_r[addr_i] <= wdata_i;
      end
      rdata_o <= mem_r[addr_i];
   end

endmodule // csr_gpr_mem

// ### testbench/csr_props.sv
`include "csr_defs.vh"

module csr_props #(
   parameter PC_W = 11
) (
   // clock and reset
   input logic            SYS_CLK_I,
   input logic            RST_N_I,
   // register bus
   input logic [6:0]      AVS_ADDRESS_I,
   input logic            AVS_READ_I,
   input logic            AVS_WRITE_I,
   input logic [31:0]     AVS_WRITEDATA_I,
   input logic [3:0]      AVS_BYTEENABLE_I,
   input logic [31:0]     AVS_READDATA_O,
   input logic            AVS_WAITREQUEST_O,
   // core side
   input logic            INSTR_STEP_I,
   input logic            JUMP_I,
   input logic            CALL_I,
   input logic            RET_I,
   input logic [9:0]      TARGET_I,
   input logic [PC_W-1:0] PC_O,
   input logic            ALU_EN_I,
   input logic [2:0]      ALU_OP_I,
   input logic [7:0]      ALU_A_I,
   input logic [7:0]      ALU_B_I,
   input logic [7:0]      ALU_RES_O,
   input logic [7:0]      PORT_B_DATA_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // a bus write may target the low byte, so counter checks skip it
   wire calm    = !RET_I && !AVS_WRITE_I;
   wire idle    = calm && !JUMP_I && !CALL_I;
   wire rd_done = !AVS_WAITREQUEST_O && AVS_READ_I;
   wire wr_done = !AVS_WAITREQUEST_O && AVS_WRITE_I && AVS_BYTEENABLE_I[0];

   AST_PC_STEP:
      assert property (idle && INSTR_STEP_I |=> PC_O == PC_W'($past(PC_O) + 1))
         else $error("counter did not advance");
   AST_PC_HOLD:
      assert property (idle && !INSTR_STEP_I |=> $stable(PC_O))
         else $error("counter moved without cause");
   AST_PC_LOAD:
      assert property (calm && (JUMP_I || CALL_I) |=> PC_O[9:0] == $past(TARGET_I))
         else $error("target not loaded");
   AST_CALL_RET:
      assert property (calm && CALL_I ##1 RET_I && !AVS_WRITE_I
                       |=> PC_O == PC_W'($past(PC_O, 2) + 1))
         else $error("return address wrong");
   AST_ADD:
      assert property (ALU_EN_I && ALU_OP_I == `CSR_OP_ADD
                       |=> ALU_RES_O == 8'($past(ALU_A_I) + $past(ALU_B_I)))
         else $error("sum wrong");
   AST_SUB:
      assert property (ALU_EN_I && ALU_OP_I == `CSR_OP_SUB
                       |=> ALU_RES_O == 8'($past(ALU_A_I) - $past(ALU_B_I)))
         else $error("difference wrong");
   AST_PORT_A_DATA_HI:
      assert property (rd_done && AVS_ADDRESS_I == 7'h05 |-> AVS_READDATA_O[31:4] == 28'h0)
         else $error("port a upper bits set");
   AST_PORT_B_DATA_LATCH:
      assert property (wr_done && AVS_ADDRESS_I == 7'h06
                       |=> PORT_B_DATA_O == $past(AVS_WRITEDATA_I[7:0]))
         else $error("port b latch not written");

   cover property (CALL_I ##1 RET_I);
   cover property (rd_done && AVS_ADDRESS_I == 7'h00);
   cover property (ALU_EN_I && ALU_OP_I == `CSR_OP_SUB);
endmodule // csr_props

bind csr_top csr_props #(.PC_W(PC_W)) u_csr_props (.*);

// ### testbench/csr_pin_model.sv
module csr_pin_model (
   // outside world
   input  logic       tmr_i,
   input  logic [3:0] a_i,
   input  logic [7:0] b_i,
   // port c latch, driven onto its pins
   input  logic [7:0] c_latch_i,
   // pin levels seen by the block
   output logic       tmr_o,
   output logic [3:0] a_o,
   output logic [7:0] b_o,
   output logic [7:0] c_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign tmr_o = tmr_i;
   assign a_o   = a_i;
   assign b_o   = b_i;
   // port c runs as output, so its pins echo the latch
   assign c_o   = c_latch_i;
endmodule // csr_pin_model

// ### testbench/testbench.sv
`include "csr_defs.vh"

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic [6:0]  addr  = 7'h00;
   logic        rd    = 1'b0;
   logic        wr    = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [7:0]  ev    = 8'h00; // step jump call ret alu sleep watchdog_clear_op ovf
   logic [9:0]  tgt   = 10'h000;
   logic [2:0]  op    = 3'h0;
   logic [7:0]  opa   = 8'h00;
   logic [7:0]  opb   = 8'h00;
   logic        tmr   = 1'b0;
   logic [3:0]  ext_a = 4'h0;
   logic [7:0]  ext_b = 8'h00;
   logic [31:0] rdata;
   logic        waitreq;
   logic [10:0] pc;
   logic [7:0]  res, q, pb_o, pc_o, pb_pin, pc_pin;
   logic [3:0]  pa_o, pa_pin;
   logic        tmr_pin;
   int          fails = 0;
   int          tests_run = 0;
   int          cycles = 0;

   always #20 clk = ~clk;

   csr_top u_csr_top (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'h1),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .INSTR_STEP_I(ev[7]),
      .JUMP_I(ev[6]), .CALL_I(ev[5]), .RET_I(ev[4]), .TARGET_I(tgt), .PC_O(pc),
      .ALU_EN_I(ev[3]), .ALU_OP_I(op), .ALU_A_I(opa), .ALU_B_I(opb), .ALU_RES_O(res),
      .SLEEP_I(ev[2]), .WATCHDOG_CLEAR_OP_I(ev[1]), .WDT_OVF_I(ev[0]), .TMR_PIN_I(tmr_pin),
      .PORT_A_DATA_PIN_I(pa_pin), .PORT_B_DATA_PIN_I(pb_pin), .PORT_C_DATA_PIN_I(pc_pin),
      .PORT_A_DATA_O(pa_o), .PORT_B_DATA_O(pb_o), .PORT_C_DATA_O(pc_o));

   csr_pin_model u_csr_pin_model (
      .tmr_i(tmr), .a_i(ext_a), .b_i(ext_b), .c_latch_i(pc_o),
      .tmr_o(tmr_pin), .a_o(pa_pin), .b_o(pb_pin), .c_o(pc_pin));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // holds the request until waitrequest is sampled low
   task bus(input logic w, input logic [6:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= {24'h0, d};
      do @(posedge clk); while (waitreq !== 1'b0 && ++n < 20);
      if (n >= 20) begin
         fails++;
         $display("ERROR %0t bus answer missing", $time);
      end
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(negedge clk);
   endtask

   task rchk(input logic [6:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask

   task pulse(input logic [7:0] v, input logic [9:0] t = 10'h000);
      @(posedge clk);
      ev <= v;
      tgt <= t;
      @(posedge clk);
      ev <= 8'h00;
      @(negedge clk);
   endtask

   task alu(input logic [2:0] o, input logic [7:0] a, b, er, es);
      @(posedge clk);
      op <= o;
      opa <= a;
      opb <= b;
      pulse(8'h08);
      chk(res, er);
      rchk(7'h03, es);
   endtask

   task t_regs;
      rchk(7'h03, 8'h18);
      rchk(7'h04, 8'h00);
      rchk(7'h08, 8'h00);
   endtask

   task t_ind;
      bus(1'b1, 7'h38, 8'h10);
      bus(1'b1, 7'h39, 8'h0a);
      bus(1'b1, 7'h04, 8'h38);
      rchk(7'h00, 8'h10);
      bus(1'b1, 7'h04, 8'h39);
      rchk(7'h00, 8'h0a);
      bus(1'b1, 7'h04, 8'h00);
      bus(1'b1, 7'h00, 8'h55);
      rchk(7'h00, 8'h00);
      bus(1'b1, 7'h04, 8'h30);
      bus(1'b1, 7'h00, 8'h11);
      bus(1'b1, 7'h04, 8'h70);
      bus(1'b1, 7'h00, 8'ha5);
      bus(1'b1, 7'h04, 8'h30);
      rchk(7'h00, 8'h11);
      bus(1'b1, 7'h04, 8'hc6);
      bus(1'b1, 7'h00, 8'h3c);
      chk(pb_o, 8'h3c);
      bus(1'b1, 7'h04, 8'h00);
   endtask

   task t_tmr;
      bus(1'b1, 7'h40, 8'h08);
      bus(1'b1, 7'h01, 8'h00);
      repeat (5) pulse(8'h80);
      rchk(7'h01, 8'h05);
      for (int e = 0; e < 2; e++) begin
         bus(1'b1, 7'h40, {3'b001, e[0], 4'h8});
         bus(1'b1, 7'h01, 8'h00);
         repeat (3) begin
            repeat (6) @(posedge clk);
            tmr <= ~tmr;
         end
         repeat (6) @(posedge clk);
         rchk(7'h01, 8'h02);
      end
      bus(1'b1, 7'h40, 8'h00);
      bus(1'b1, 7'h01, 8'h00);
      pulse(8'h80);
      bus(1'b1, 7'h01, 8'h10);
      pulse(8'h80);
      rchk(7'h01, 8'h10);
      pulse(8'h80);
      rchk(7'h01, 8'h11);
   endtask

   task t_pc;
      bus(1'b1, 7'h0a, 8'h04);
      pulse(8'h40, 10'h123);
      chk(pc, 11'h523);
      @(posedge clk);
      ev <= 8'h20;
      tgt <= 10'h050;
      @(posedge clk);
      ev <= 8'h10;
      @(posedge clk);
      ev <= 8'h00;
      @(negedge clk);
      chk(pc, 11'h524);
      bus(1'b1, 7'h02, 8'h77);
      chk(pc, 11'h477);
      rchk(7'h0a, 8'h04);
      pulse(8'h80);
      chk(pc, 11'h478);
   endtask

   task t_alu;
      bus(1'b1, 7'h03, 8'he7);
      rchk(7'h03, 8'hff);
      bus(1'b1, 7'h03, 8'h00);
      rchk(7'h03, 8'h18);
      alu(`CSR_OP_ADD, 8'h0f, 8'h01, 8'h10, 8'h1a);
      alu(`CSR_OP_ADD, 8'hf0, 8'h20, 8'h10, 8'h19);
      alu(`CSR_OP_SUB, 8'h10, 8'h01, 8'h0f, 8'h19);
      alu(`CSR_OP_SUB, 8'h05, 8'h05, 8'h00, 8'h1f);
      alu(`CSR_OP_RL, 8'h00, 8'h00, 8'h01, 8'h1e);
      alu(`CSR_OP_RR, 8'h03, 8'h00, 8'h01, 8'h1f);
   endtask

   task t_flags;
      pulse(8'h04);
      rchk(7'h03, 8'h17);
      pulse(8'h01);
      rchk(7'h03, 8'h07);
      pulse(8'h02);
      rchk(7'h03, 8'h1f);
   endtask

   task t_ports;
      @(posedge clk);
      ext_a <= 4'ha;
      ext_b <= 8'h5c;
      bus(1'b1, 7'h07, 8'h81);
      repeat (5) @(posedge clk);
      rchk(7'h05, 8'h0a);
      rchk(7'h06, 8'h5c);
      rchk(7'h07, 8'h81);
      bus(1'b1, 7'h05, 8'hff);
      chk(pa_o, 4'hf);
   endtask

   task results;
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // a few thousand cycles suffice; a stuck handshake ends in bus after 20 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         $display("ERROR %0t timeout", $time);
         results;
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_ind;
      t_tmr;
      t_pc;
      t_alu;
      t_flags;
      t_ports;
      results;
   end
endmodule // testbench
